// [core/ezc_zone_ctrl.sv]
// egress zone controller: lock, escort, alarms, apb registers and interrupt
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ezc_zone_ctrl
    import ezc_pkg::*;
(
    input wire logic clk, // system clock 125 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic tag_present, // zone receiver sees a tag
    input wire logic door_open, // door switch, high when open
    input wire logic lock_blocked, // lock obstructed
    input wire logic elev_door_open, // elevator doors open at floor
    input wire logic motion_sensor, // hallway motion detected
    input wire logic key_valid, // keypad valid code, level from pad
    input wire logic key_reset, // keypad reset, level from pad
    input wire logic self_clear_jumper, // auto-reset jumper fitted
    input wire logic wiring_fault, // supervision: wiring or antenna fault
    input wire logic rx_fault, // supervision: receiver fault
    input wire logic band_tamper, // tag reports band removed or cut
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic lock_out, // door lock drive
    output logic call_inhibit, // elevator call button inhibit
    output logic elev_hold, // elevator door hold
    output logic egress_alarm, // egress alarm output
    output logic loiter_alarm, // loiter alarm output
    output logic ajar_alarm, // door-ajar alarm output
    output logic supv_alarm, // supervisor alarm output
    output logic band_alarm, // band alarm output
    output logic irq // level interrupt
);
    localparam int NIN = SYNC_COUNT;

    typedef struct packed {
        logic [31:0] div;
        logic tick;
        logic [5:0] ctrl;
        logic [6:0] escort_s;
        logic [6:0] loiter_s;
        logic [6:0] ajar_s;
        logic [6:0] holdoff_s;
        logic [6:0] supv_s;
        logic [NUM_IRQ-1:0] irq_stat;
        logic [NUM_IRQ-1:0] irq_mask;
        logic [6:0] esc_left;
        logic escort;
        logic [6:0] mute_left;
        logic lock;
        logic egress;
        logic loiter;
        logic ajar;
        logic elev_hold;
        logic [1:0] key_hist;
        logic [31:0] rdata;
    } ezc_st_t;

    ezc_st_t st_ff;
    ezc_st_t nxt_st;

    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] syn;
    logic tag;
    logic door;
    logic blocked;
    logic edoor;
    logic motion;
    logic kvalid;
    logic kreset;
    logic jumper;
    logic wfault;
    logic rfault;
    logic band;
    logic holdoff_done;
    logic loiter_hit;
    logic ajar_hit;
    logic kvalid_pulse;
    logic kreset_pulse;
    logic wr_acc;
    logic rd_acc;
    logic hall;
    logic elev;
    logic rx_muted;
    logic supv;
    logic [NUM_IRQ-1:0] events;
    logic [6:0] wdata7;
    logic [31:0] rd_mux;
    logic lock_ok;
    logic egress_cause;
    logic [7:0] status_word;

    assign raw_in = {band_tamper, rx_fault, wiring_fault, self_clear_jumper, key_reset,
                     key_valid, motion_sensor, elev_door_open, lock_blocked, door_open,
                     tag_present};

    // every zone input level passes two flops before any logic reads it
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            ezc_sync u_sync (
                .clk(clk),
                .rst_n(rst_n),
                .async_in(raw_in[gi]),
                .sync_out(syn[gi])
            );
        end
    endgenerate

    assign {band, rfault, wfault, jumper, kreset, kvalid, motion, edoor, blocked, door, tag} = syn;

    assign hall = st_ff.ctrl[CTRL_HALL_ZONE];
    assign elev = st_ff.ctrl[CTRL_ELEV_ZONE];
    assign kvalid_pulse = kvalid & ~st_ff.key_hist[0];
    assign kreset_pulse = kreset & ~st_ff.key_hist[1];

    // hold-off counts while tag is gone and lock still engaged
    ezc_sec_timer u_holdoff (
        .clk(clk),
        .rst_n(rst_n),
        .sec_tick(st_ff.tick),
        .run(st_ff.lock & ~tag),
        .limit(st_ff.holdoff_s),
        .expired(holdoff_done)
    );

    ezc_sec_timer u_loiter (
        .clk(clk),
        .rst_n(rst_n),
        .sec_tick(st_ff.tick),
        .run(tag & st_ff.ctrl[CTRL_LOITER_EN]),
        .limit(st_ff.loiter_s),
        .expired(loiter_hit)
    );

    ezc_sec_timer u_ajar (
        .clk(clk),
        .rst_n(rst_n),
        .sec_tick(st_ff.tick),
        .run(door & st_ff.ctrl[CTRL_AJAR_EN]),
        .limit(st_ff.ajar_s),
        .expired(ajar_hit)
    );

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign wdata7 = pwdata[6:0];

    // receiver faults are muted for the supervise interval after a keypad reset
    assign rx_muted = (st_ff.mute_left != 7'h00);
    assign supv = wfault | (rfault & ~rx_muted);

    assign events = {band, supv, st_ff.ajar, st_ff.loiter, st_ff.egress};

    // lock engages only on a closed, unobstructed and fitted door
    assign lock_ok = !door && !blocked && st_ff.ctrl[CTRL_LOCK_FITTED]
                     && (!hall || st_ff.ctrl[CTRL_HALL_LOCK]);

    // the egress cause depends on the kind of zone
    assign egress_cause = (!hall && door) || (hall && motion) || (elev && edoor);

    assign status_word = {st_ff.elev_hold, st_ff.escort, st_ff.lock, band, supv,
                          st_ff.ajar, st_ff.loiter, st_ff.egress};

    // only the low address byte is decoded, so registers alias upward
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr[7:0] == REG_CTRL) begin
            rd_mux[5:0] = st_ff.ctrl;
        end else if (paddr[7:0] == REG_ESCORT) begin
            rd_mux[6:0] = st_ff.escort_s;
        end else if (paddr[7:0] == REG_LOITER) begin
            rd_mux[6:0] = st_ff.loiter_s;
        end else if (paddr[7:0] == REG_AJAR) begin
            rd_mux[6:0] = st_ff.ajar_s;
        end else if (paddr[7:0] == REG_HOLDOFF) begin
            rd_mux[6:0] = st_ff.holdoff_s;
        end else if (paddr[7:0] == REG_SUPV) begin
            rd_mux[6:0] = st_ff.supv_s;
        end else if (paddr[7:0] == REG_STATUS) begin
            rd_mux[7:0] = status_word;
        end else if (paddr[7:0] == REG_IRQ_STAT) begin
            rd_mux[NUM_IRQ-1:0] = st_ff.irq_stat;
        end else if (paddr[7:0] == REG_IRQ_MASK) begin
            rd_mux[NUM_IRQ-1:0] = st_ff.irq_mask;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.key_hist = {kreset, kvalid};
        nxt_st.rdata = rd_mux;

        // one-second tick
        if (st_ff.div >= TICK_CYCLES_32 - 32'h1) begin
            nxt_st.div = 32'h0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.div = st_ff.div + 32'h1;
            nxt_st.tick = 1'b0;
        end

        // escort interval
        if (kvalid_pulse) begin
            nxt_st.escort = (st_ff.escort_s != 7'h00);
            nxt_st.esc_left = st_ff.escort_s;
        end else if (st_ff.escort && st_ff.tick) begin
            if (st_ff.esc_left <= 7'h01) begin
                nxt_st.escort = 1'b0;
                nxt_st.esc_left = 7'h00;
            end else begin
                nxt_st.esc_left = st_ff.esc_left - 7'h01;
            end
        end

        // supervise mute interval
        if (kreset_pulse) begin
            nxt_st.mute_left = st_ff.supv_s;
        end else if (rx_muted && st_ff.tick) begin
            nxt_st.mute_left = st_ff.mute_left - 7'h01;
        end

        // lock control
        if (st_ff.escort || kvalid_pulse) begin
            nxt_st.lock = 1'b0;
        end else if (tag && !st_ff.lock && lock_ok) begin
            nxt_st.lock = 1'b1;
        end else if (st_ff.lock && holdoff_done) begin
            nxt_st.lock = 1'b0;
        end

        // latched egress alarm
        if (st_ff.egress) begin
            if (kvalid_pulse && !tag && !door) begin
                nxt_st.egress = 1'b0;
            end
        end else if (!st_ff.escort && tag) begin
            if (egress_cause) begin
                nxt_st.egress = 1'b1;
            end
        end

        // elevator door hold until a valid code
        if (kvalid_pulse) begin
            nxt_st.elev_hold = 1'b0;
        end else if (elev && tag && edoor && !st_ff.escort) begin
            nxt_st.elev_hold = 1'b1;
        end

        // loiter alarm
        if (loiter_hit && !st_ff.escort) begin
            nxt_st.loiter = 1'b1;
        end else if (st_ff.loiter && !tag && (kreset_pulse || jumper)) begin
            nxt_st.loiter = 1'b0;
        end

        // door-ajar alarm
        if (ajar_hit && !st_ff.escort) begin
            nxt_st.ajar = 1'b1;
        end else if (st_ff.ajar && !door && (kreset_pulse || jumper)) begin
            nxt_st.ajar = 1'b0;
        end

        // register writes
        if (wr_acc) begin
            if (paddr[7:0] == REG_CTRL) begin
                nxt_st.ctrl = pwdata[5:0];
            end else if (paddr[7:0] == REG_ESCORT) begin
                nxt_st.escort_s = (wdata7 > ESCORT_MAX) ? ESCORT_MAX : wdata7;
            end else if (paddr[7:0] == REG_LOITER) begin
                nxt_st.loiter_s = (wdata7 < WIN_MIN) ? WIN_MIN :
                                  (wdata7 > WIN_MAX) ? WIN_MAX : wdata7;
            end else if (paddr[7:0] == REG_AJAR) begin
                nxt_st.ajar_s = (wdata7 == 7'h00) ? 7'h00 :
                                (wdata7 < WIN_MIN) ? WIN_MIN :
                                (wdata7 > WIN_MAX) ? WIN_MAX : wdata7;
            end else if (paddr[7:0] == REG_HOLDOFF) begin
                nxt_st.holdoff_s = wdata7;
            end else if (paddr[7:0] == REG_SUPV) begin
                nxt_st.supv_s = wdata7;
            end else if (paddr[7:0] == REG_IRQ_MASK) begin
                nxt_st.irq_mask = pwdata[NUM_IRQ-1:0];
            end
        end

        // sticky interrupt status: set wins over write-one-to-clear
        if (wr_acc && paddr[7:0] == REG_IRQ_STAT) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[NUM_IRQ-1:0];
        end
        nxt_st.irq_stat = nxt_st.irq_stat | events;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.escort_s <= ESCORT_RST;
            st_ff.loiter_s <= LOITER_RST;
            st_ff.ajar_s <= AJAR_RST;
            st_ff.holdoff_s <= HOLDOFF_RST;
            st_ff.supv_s <= SUPV_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // no wait states; setup phase latches read data, access phase returns it
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = rd_acc ? st_ff.rdata : 32'h0000_0000;

    assign lock_out = st_ff.lock;
    assign call_inhibit = elev & tag & ~st_ff.escort;
    assign elev_hold = st_ff.elev_hold;
    // egress alarm silenced during escort
    assign egress_alarm = st_ff.egress & ~st_ff.escort;
    assign loiter_alarm = st_ff.loiter;
    assign ajar_alarm = st_ff.ajar;
    assign supv_alarm = supv;
    assign band_alarm = band;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);
endmodule

// [core/ezc_pkg.sv]
// package with constants, register map, bit positions and reset values for the egress zone controller
package ezc_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam logic [31:0] TICK_CYCLES_32 = 32'(TICK_CYCLES);
    localparam int unsigned SYNC_COUNT = 11;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ESCORT = 8'h04;
    localparam logic [7:0] REG_LOITER = 8'h08;
    localparam logic [7:0] REG_AJAR = 8'h0C;
    localparam logic [7:0] REG_HOLDOFF = 8'h10;
    localparam logic [7:0] REG_SUPV = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h20;

    // control bits
    localparam int CTRL_LOCK_FITTED = 0;
    localparam int CTRL_LOITER_EN = 1;
    localparam int CTRL_AJAR_EN = 2;
    localparam int CTRL_ELEV_ZONE = 3;
    localparam int CTRL_HALL_ZONE = 4;
    localparam int CTRL_HALL_LOCK = 5;

    // status and interrupt bits
    localparam int ST_EGRESS = 0;
    localparam int ST_LOITER = 1;
    localparam int ST_AJAR = 2;
    localparam int ST_SUPV = 3;
    localparam int ST_BAND = 4;
    localparam int ST_LOCK = 5;
    localparam int ST_ESCORT = 6;
    localparam int ST_ELEV_HOLD = 7;
    localparam int NUM_IRQ = 5;

    // reset values and write limits
    localparam logic [5:0] CTRL_RST = 6'h01;
    localparam logic [6:0] ESCORT_RST = 7'h0A;
    localparam logic [6:0] LOITER_RST = 7'h0F;
    localparam logic [6:0] AJAR_RST = 7'h0F;
    localparam logic [6:0] HOLDOFF_RST = 7'h05;
    localparam logic [6:0] SUPV_RST = 7'h3C;
    localparam logic [6:0] ESCORT_MAX = 7'h62;
    localparam logic [6:0] WIN_MIN = 7'h0A;
    localparam logic [6:0] WIN_MAX = 7'h6E;
endpackage

// [core/ezc_sync.sv]
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module ezc_sync
    import ezc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic async_in, // level from outside the clock domain
    output logic sync_out // synchronised level
);
    typedef struct packed {
        logic meta;
        logic sync;
    } ezc_sync_st_t;

    ezc_sync_st_t st_ff;
    ezc_sync_st_t nxt_st;

    always_comb begin
        nxt_st.meta = async_in;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.sync;
endmodule

// [core/ezc_sec_timer.sv]
// seconds down-counter that runs while enabled and flags expiry
`timescale 1ns/1ps
module ezc_sec_timer
    import ezc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic sec_tick, // one-cycle pulse each second
    input wire logic run, // count while high, reload while low
    input wire logic [6:0] limit, // seconds to wait
    output logic expired // high once run has lasted limit seconds
);
    typedef struct packed {
        logic [6:0] left;
        logic done;
    } ezc_tmr_st_t;

    ezc_tmr_st_t st_ff;
    ezc_tmr_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!run) begin
            nxt_st.left = limit;
            nxt_st.done = 1'b0;
        end else if (st_ff.left == 7'h00) begin
            nxt_st.done = 1'b1;
        end else if (sec_tick) begin
            nxt_st.left = st_ff.left - 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign expired = st_ff.done;
endmodule

// [sim/ezc_zone_env.sv]
// zone surroundings model: tag receiver, door with magnetic lock, keypad
`timescale 1ns/1ps
module ezc_zone_env (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic lock_out, // lock drive from controller
    input wire logic want_tag, // bench: tag walks into zone
    input wire logic want_door, // bench: someone pulls the door
    input wire logic want_key, // bench: valid code typed
    output logic tag_present, // receiver sees tag
    output logic door_open, // door switch
    output logic lock_blocked, // lock obstruction
    output logic key_valid // keypad valid code level
);
    logic [2:0] key_cnt;
    logic key_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tag_present <= 1'b0;
            door_open <= 1'b0;
            key_d <= 1'b0;
            key_cnt <= 3'h0;
        end else begin
            tag_present <= want_tag;
            // an engaged lock keeps a closed door shut
            if (!want_door) begin
                door_open <= 1'b0;
            end else if (!lock_out) begin
                door_open <= 1'b1;
            end
            key_d <= want_key;
            // each code entry gives a level of six cycles
            if (want_key && !key_d) begin
                key_cnt <= 3'h6;
            end else if (key_cnt != 3'h0) begin
                key_cnt <= key_cnt - 3'h1;
            end
        end
    end
    assign key_valid = (key_cnt != 3'h0);
    assign lock_blocked = 1'b0;
endmodule

// [sim/ezc_zone_ctrl_sva.sv]
// concurrent checks on the zone controller ports
`timescale 1ns/1ps
module ezc_zone_ctrl_sva (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic tag_present, // tag in zone
    input wire logic key_valid, // valid code
    input wire logic elev_door_open, // elevator doors open
    input wire logic wiring_fault, // wiring fault
    input wire logic rx_fault, // receiver fault
    input wire logic band_tamper, // band report
    input wire logic lock_out, // lock drive
    input wire logic call_inhibit, // call inhibit
    input wire logic elev_hold, // elevator hold
    input wire logic egress_alarm, // egress alarm
    input wire logic supv_alarm, // supervisor alarm
    input wire logic band_alarm // band alarm
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_band;
        band_alarm == $past(band_tamper, 2);
    endproperty
    a_band: assert property (p_band) else $error("band alarm not following report");
    property p_call;
        call_inhibit |-> $past(tag_present, 2);
    endproperty
    a_call: assert property (p_call) else $error("call inhibit without tag");
    property p_supv_set;
        $past(wiring_fault, 2) |-> supv_alarm;
    endproperty
    a_supv_set: assert property (p_supv_set) else $error("wiring fault not alarmed");
    property p_supv_clr;
        supv_alarm |-> $past(wiring_fault, 2) || $past(rx_fault, 2);
    endproperty
    a_supv_clr: assert property (p_supv_clr) else $error("supervisor alarm without fault");
    property p_egress_hold;
        $fell(egress_alarm) |-> $past(key_valid, 2) || $past(key_valid, 4);
    endproperty
    a_egress_hold: assert property (p_egress_hold) else $error("egress alarm dropped alone");
    property p_lock_rise;
        $rose(lock_out) |-> $past(tag_present, 3);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock engaged without tag");
    property p_key_unlock;
        $rose(key_valid) |-> ##[2:5] !lock_out;
    endproperty
    a_key_unlock: assert property (p_key_unlock) else $error("code did not release lock");
    property p_hold_rise;
        $rose(elev_hold) |-> $past(tag_present, 3) && $past(elev_door_open, 3);
    endproperty
    a_hold_rise: assert property (p_hold_rise) else $error("elevator hold without cause");
    property p_hold_fall;
        $fell(elev_hold) |-> $past(key_valid, 2) || $past(key_valid, 4);
    endproperty
    a_hold_fall: assert property (p_hold_fall) else $error("elevator hold dropped alone");
    c_egress: cover property ($rose(egress_alarm));
    c_hold: cover property ($rose(elev_hold));
    c_lock: cover property ($rose(lock_out));
endmodule
bind ezc_zone_ctrl ezc_zone_ctrl_sva chk_u (.clk(clk), .rst_n(rst_n), .tag_present(tag_present),
    .key_valid(key_valid), .elev_door_open(elev_door_open), .wiring_fault(wiring_fault),
    .rx_fault(rx_fault), .band_tamper(band_tamper), .lock_out(lock_out),
    .call_inhibit(call_inhibit), .elev_hold(elev_hold), .egress_alarm(egress_alarm),
    .supv_alarm(supv_alarm), .band_alarm(band_alarm));

// [sim/ezc_zone_ctrl_tb_top.sv]
// self-checking testbench for the egress zone controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module ezc_zone_ctrl_tb_top;
    import ezc_pkg::*;
    localparam logic [7:0] RA [8] = '{REG_CTRL, REG_ESCORT, REG_LOITER, REG_AJAR, REG_HOLDOFF,
        REG_SUPV, REG_IRQ_MASK, 8'h40};
    localparam logic [31:0] RV [8] = '{32'h01, 32'h0A, 32'h0F, 32'h0F, 32'h05, 32'h3C, 32'h0, 32'h0};
    logic clk, rst_n, want_tag, want_door, want_key, tag_present, door_open, lock_blocked;
    logic key_valid, elev_door_open, motion_sensor, key_reset, self_clear_jumper;
    logic wiring_fault, rx_fault, band_tamper, psel, penable, pwrite, pready, pslverr;
    logic lock_out, call_inhibit, elev_hold, egress_alarm, loiter_alarm, ajar_alarm;
    logic supv_alarm, band_alarm, irq;
    logic [31:0] paddr, pwdata, prdata;
    int n_mismatch = 0;
    int num_checks = 0;
    ezc_zone_env env_u (.clk(clk), .rst_n(rst_n), .lock_out(lock_out), .want_tag(want_tag),
        .want_door(want_door), .want_key(want_key), .tag_present(tag_present),
        .door_open(door_open), .lock_blocked(lock_blocked), .key_valid(key_valid));
    ezc_zone_ctrl dut_u (.clk(clk), .rst_n(rst_n), .tag_present(tag_present),
        .door_open(door_open), .lock_blocked(lock_blocked), .elev_door_open(elev_door_open),
        .motion_sensor(motion_sensor), .key_valid(key_valid), .key_reset(key_reset),
        .self_clear_jumper(self_clear_jumper), .wiring_fault(wiring_fault), .rx_fault(rx_fault),
        .band_tamper(band_tamper), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lock_out(lock_out), .call_inhibit(call_inhibit), .elev_hold(elev_hold),
        .egress_alarm(egress_alarm), .loiter_alarm(loiter_alarm), .ajar_alarm(ajar_alarm),
        .supv_alarm(supv_alarm), .band_alarm(band_alarm), .irq(irq));
    always #4 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask
    task automatic do_reset();
        want_tag <= 1'b0;
        want_door <= 1'b0;
        settle();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    // one apb transfer, request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        `CHK("pslverr", 1'b0, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        `CHK("prdata", ex, r)
    endtask
    task automatic press_key();
        want_key <= 1'b1;
        settle();
        want_key <= 1'b0;
        settle();
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            rdc(RA[i], RV[i]);
        end
        wr(8'h40, 32'h5A);
        rdc(8'h40, 32'h0);
        wr(REG_ESCORT, 32'h7F);
        rdc(REG_ESCORT, 32'h62);
        wr(REG_LOITER, 32'h05);
        rdc(REG_LOITER, 32'h0A);
        $display("test regs done");
    endtask
    task automatic t_lock();
        do_reset();
        want_tag <= 1'b1;
        settle();
        `CHK("lock_out", 1'b1, lock_out)
        want_door <= 1'b1;
        settle();
        `CHK("egress_alarm", 1'b0, egress_alarm)
        want_door <= 1'b0;
        want_tag <= 1'b0;
        settle();
        `CHK("lock_out", 1'b1, lock_out)
        press_key();
        `CHK("lock_out", 1'b0, lock_out)
        do_reset();
        `CHK("lock_out", 1'b0, lock_out)
        $display("test lock done");
    endtask
    task automatic t_egress();
        wr(REG_ESCORT, 32'h0);
        wr(REG_IRQ_MASK, 32'h1F);
        want_door <= 1'b1;
        settle();
        want_tag <= 1'b1;
        settle();
        `CHK("egress_alarm", 1'b1, egress_alarm)
        `CHK("lock_out", 1'b0, lock_out)
        `CHK("irq", 1'b1, irq)
        want_tag <= 1'b0;
        settle();
        `CHK("egress_alarm", 1'b1, egress_alarm)
        press_key();
        `CHK("egress_alarm", 1'b1, egress_alarm)
        want_door <= 1'b0;
        settle();
        `CHK("egress_alarm", 1'b1, egress_alarm)
        press_key();
        `CHK("egress_alarm", 1'b0, egress_alarm)
        wr(REG_IRQ_MASK, 32'h0);
        `CHK("irq", 1'b0, irq)
        rdc(REG_IRQ_STAT, 32'h01);
        wr(REG_IRQ_STAT, 32'h01);
        rdc(REG_IRQ_STAT, 32'h0);
        $display("test egress done");
    endtask
    task automatic t_elev();
        do_reset();
        wr(REG_CTRL, 32'h08);
        want_tag <= 1'b1;
        settle();
        `CHK("call_inhibit", 1'b1, call_inhibit)
        `CHK("elev_hold", 1'b0, elev_hold)
        elev_door_open <= 1'b1;
        settle();
        `CHK("egress_alarm", 1'b1, egress_alarm)
        `CHK("elev_hold", 1'b1, elev_hold)
        want_tag <= 1'b0;
        settle();
        `CHK("call_inhibit", 1'b0, call_inhibit)
        `CHK("elev_hold", 1'b1, elev_hold)
        press_key();
        `CHK("elev_hold", 1'b0, elev_hold)
        elev_door_open <= 1'b0;
        $display("test elevator done");
    endtask
    task automatic t_hall();
        do_reset();
        wr(REG_CTRL, 32'h33);
        want_tag <= 1'b1;
        settle();
        `CHK("egress_alarm", 1'b0, egress_alarm)
        `CHK("lock_out", 1'b1, lock_out)
        `CHK("loiter_alarm", 1'b0, loiter_alarm)
        motion_sensor <= 1'b1;
        settle();
        `CHK("egress_alarm", 1'b1, egress_alarm)
        press_key();
        `CHK("egress_alarm", 1'b0, egress_alarm)
        motion_sensor <= 1'b0;
        $display("test hallway done");
    endtask
    task automatic t_ajar();
        do_reset();
        wr(REG_AJAR, 32'h0);
        wr(REG_CTRL, 32'h04);
        want_door <= 1'b1;
        settle();
        `CHK("ajar_alarm", 1'b1, ajar_alarm)
        want_door <= 1'b0;
        settle();
        `CHK("ajar_alarm", 1'b1, ajar_alarm)
        key_reset <= 1'b1;
        settle();
        key_reset <= 1'b0;
        settle();
        `CHK("ajar_alarm", 1'b0, ajar_alarm)
        self_clear_jumper <= 1'b1;
        want_door <= 1'b1;
        settle();
        `CHK("ajar_alarm", 1'b1, ajar_alarm)
        want_door <= 1'b0;
        settle();
        `CHK("ajar_alarm", 1'b0, ajar_alarm)
        self_clear_jumper <= 1'b0;
        $display("test ajar done");
    endtask
    task automatic t_faults();
        // drop the supervise mute left running by the keypad reset
        do_reset();
        wiring_fault <= 1'b1;
        settle();
        `CHK("supv_alarm", 1'b1, supv_alarm)
        wiring_fault <= 1'b0;
        band_tamper <= 1'b1;
        settle();
        `CHK("supv_alarm", 1'b0, supv_alarm)
        `CHK("band_alarm", 1'b1, band_alarm)
        band_tamper <= 1'b0;
        rx_fault <= 1'b1;
        settle();
        `CHK("supv_alarm", 1'b1, supv_alarm)
        key_reset <= 1'b1;
        settle();
        key_reset <= 1'b0;
        `CHK("supv_alarm", 1'b0, supv_alarm)
        rx_fault <= 1'b0;
        settle();
        $display("test faults done");
    endtask
    initial begin
        {clk, rst_n, want_tag, want_door, want_key, elev_door_open, motion_sensor} = 7'h00;
        {key_reset, self_clear_jumper, wiring_fault, rx_fault, band_tamper} = 5'h00;
        {psel, penable, pwrite, paddr, pwdata} = 67'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_lock();
        t_egress();
        t_elev();
        t_hall();
        t_ajar();
        t_faults();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule
